// ===== common/cdu_defines.svh
// offsets, field positions, blank value and timing counts of the configuration loader
`ifndef CDU_DEFINES_SVH
`define CDU_DEFINES_SVH
`define CDU_CLK_NS 40
`define CDU_SEQ_DELAY_NS 500000
`define CDU_SEQ_FETCH_NS 10000
`define CDU_SEQ_DELAY_CYC ((`CDU_SEQ_DELAY_NS + `CDU_CLK_NS - 1) / `CDU_CLK_NS)
`define CDU_SEQ_FETCH_CYC (`CDU_SEQ_FETCH_NS / `CDU_CLK_NS)
`define CDU_REG_UPDCTL 16'h0090
`define CDU_REG_UDL 16'h00D8
`define CDU_RAM_TOP 16'h00DF
`define CDU_CFG_BYTES 160
`define CDU_NV_BASE 16'hF800
`define CDU_NV_CFG_TOP 16'hF89F
`define CDU_NV_USER_LO 16'hF900
`define CDU_NV_USER_TOP 16'hF9FF
`define CDU_NV_SEQ_LO 16'hFA00
`define CDU_NV_TOP 16'hFBFF
`define CDU_NV_BYTES 1024
`define CDU_SEQ_NV_OFS 10'h200
`define CDU_PAGE_BYTES 32
`define CDU_ERASE_CMD 8'hFE
`define CDU_BLANK 8'hFF
`define CDU_UPD_TRANSP 0
`define CDU_UPD_COMMIT 1
`define CDU_UPD_ERASE 2
`define CDU_UDL_REQ 0
`endif

// ===== common/cdu_pkg.sv
// types of the configuration loader
`default_nettype none
package cdu_pkg;
    typedef enum logic [2:0] {
        CDU_WAIT_UV,
        CDU_LOAD_A,
        CDU_XFER,
        CDU_SEQ_WAIT,
        CDU_SEQ_FETCH,
        CDU_RUN
    } cdu_state_type;
endpackage
`default_nettype wire

// ===== rtl/cdu_loader.sv
// configuration download, update control and nonvolatile access gating
`timescale 1ns/1ps
`default_nettype none
`include "cdu_defines.svh"
module cdu_loader
    import cdu_pkg::*;
#(
    parameter int SEQ_DELAY_CYC = `CDU_SEQ_DELAY_CYC,
    parameter int SEQ_FETCH_CYC = `CDU_SEQ_FETCH_CYC
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // supply monitor pin
    input wire logic LOCKOUT_CLEAR,
    // byte access from the bus framer
    input wire logic BUS_REQ,
    input wire logic BUS_WR,
    input wire logic BUS_ERASE,
    input wire logic [15:0] BUS_ADDR,
    input wire logic [7:0] BUS_WDATA,
    output logic BUS_DONE,
    output logic BUS_ACK,
    output logic [7:0] BUS_RDATA,
    // active configuration read port
    input wire logic [7:0] CFG_SEL,
    output logic [7:0] CFG_Q,
    output logic CFG_READY,
    // sequencing engine
    input wire logic SEQ_HALTED,
    input wire logic SEQ_NEXT,
    input wire logic [5:0] SEQ_NEXT_IDX,
    output logic [63:0] SEQ_WORD,
    output logic SEQ_VALID,
    // fault recorder
    input wire logic FR_ENABLED,
    input wire logic FR_TRIGGERS_ANY
);
    typedef struct packed {
        cdu_state_type st;
        logic [2:0] sync;
        logic uv_ok;
        logic boot;
        logic [9:0] idx;
        logic [13:0] cnt;
        logic [5:0] seq_idx;
        logic transp;
        logic erase_en;
        logic [15:0] ptr;
        logic done;
        logic ack;
        logic [7:0] rdata;
        logic [7:0] cfg_q;
        logic [63:0] seq_word;
        logic seq_valid;
        logic ready;
    } cdu_regs_type;

    cdu_regs_type q_r, q_nxt;
    logic [7:0] nv [0:`CDU_NV_BYTES-1];
    logic [7:0] lat_a [0:`CDU_CFG_BYTES-1];
    logic [7:0] lat_b [0:`CDU_CFG_BYTES-1];
    logic wr_a, wr_b, ld_a, xfer_all, nv_wr, nv_erase;
    logic [7:0] wr_idx, wr_data;
    logic [9:0] nv_idx;
    logic [4:0] erase_page;
    logic in_cfg_nv, in_user_nv, in_seq_nv, is_ram, is_nv, fr_busy;

    function automatic logic [9:0] nv_ofs(input logic [15:0] a);
        nv_ofs = a[9:0];
    endfunction

    function automatic logic [63:0] state_word(input logic [5:0] i);
        logic [9:0] base;
        state_word = '0;
        base = `CDU_SEQ_NV_OFS + {1'b0, i, 3'b000};
        for (int k = 0; k < 8; k++) begin
            state_word[k*8 +: 8] = nv[base + 10'(k)];
        end
    endfunction

    // address decode of the register and nonvolatile spaces
    always_comb begin
        is_ram = BUS_ADDR <= `CDU_RAM_TOP;
        is_nv = BUS_ADDR >= `CDU_NV_BASE && BUS_ADDR <= `CDU_NV_TOP;
        in_cfg_nv = BUS_ADDR >= `CDU_NV_BASE && BUS_ADDR <= `CDU_NV_CFG_TOP;
        in_user_nv = BUS_ADDR >= `CDU_NV_USER_LO && BUS_ADDR <= `CDU_NV_USER_TOP;
        in_seq_nv = BUS_ADDR >= `CDU_NV_SEQ_LO && BUS_ADDR <= `CDU_NV_TOP;
        fr_busy = FR_ENABLED && FR_TRIGGERS_ANY;
    end

    always_comb begin
        q_nxt = q_r;
        wr_a = 1'b0;
        wr_b = 1'b0;
        ld_a = 1'b0;
        xfer_all = 1'b0;
        nv_wr = 1'b0;
        nv_erase = 1'b0;
        wr_idx = BUS_ADDR[7:0];
        wr_data = BUS_WDATA;
        nv_idx = nv_ofs(BUS_ADDR);
        erase_page = q_r.ptr[9:5];
        q_nxt.sync = {q_r.sync[1:0], LOCKOUT_CLEAR};
        // only the second and third stages are compared
        if (q_r.sync[1] == q_r.sync[2]) begin
            q_nxt.uv_ok = q_r.sync[2];
        end
        q_nxt.done = 1'b0;
        q_nxt.ack = 1'b0;
        q_nxt.cfg_q = lat_b[CFG_SEL < 8'(`CDU_CFG_BYTES) ? CFG_SEL : 8'h00];
        unique case (q_r.st)
            CDU_WAIT_UV: begin
                if (q_r.uv_ok) begin
                    q_nxt.st = CDU_LOAD_A;
                    q_nxt.idx = '0;
                    q_nxt.boot = 1'b1;
                end
            end
            CDU_LOAD_A: begin
                ld_a = 1'b1;
                q_nxt.idx = q_r.idx + 10'h001;
                if (q_r.idx == 10'(`CDU_CFG_BYTES - 1)) begin
                    q_nxt.st = CDU_XFER;
                end
            end
            CDU_XFER: begin
                xfer_all = 1'b1;
                q_nxt.cnt = '0;
                q_nxt.ready = 1'b1;
                q_nxt.st = q_r.boot ? CDU_SEQ_WAIT : CDU_RUN;
            end
            CDU_SEQ_WAIT: begin
                q_nxt.cnt = q_r.cnt + 14'h0001;
                if (q_r.cnt == 14'(SEQ_DELAY_CYC - 1)) begin
                    q_nxt.st = CDU_SEQ_FETCH;
                    q_nxt.cnt = '0;
                    q_nxt.seq_idx = '0;
                    q_nxt.boot = 1'b0;
                end
            end
            CDU_SEQ_FETCH: begin
                q_nxt.cnt = q_r.cnt + 14'h0001;
                if (q_r.cnt == 14'(SEQ_FETCH_CYC - 1)) begin
                    q_nxt.seq_word = state_word(q_r.seq_idx);
                    q_nxt.seq_valid = 1'b1;
                    q_nxt.st = CDU_RUN;
                end
            end
            CDU_RUN: begin
                // reserved last state is never fetched
                if (SEQ_NEXT && SEQ_NEXT_IDX != 6'h3F) begin
                    q_nxt.st = CDU_SEQ_FETCH;
                    q_nxt.cnt = '0;
                    q_nxt.seq_idx = SEQ_NEXT_IDX;
                end
            end
        endcase
        if (BUS_REQ) begin
            q_nxt.done = 1'b1;
            q_nxt.rdata = 8'h00;
            if (!q_r.ready || q_r.st == CDU_LOAD_A || q_r.st == CDU_XFER) begin
                q_nxt.ack = 1'b0;
            end else if (BUS_ERASE) begin
                q_nxt.ack = 1'b1;
                // erase of the state half is refused like any access there
                if (q_r.ptr >= `CDU_NV_SEQ_LO && !SEQ_HALTED) begin
                    q_nxt.ack = 1'b0;
                end else if (q_r.erase_en && q_r.ptr >= `CDU_NV_BASE && q_r.ptr <= `CDU_NV_TOP &&
                             !(fr_busy && q_r.ptr < `CDU_NV_SEQ_LO)) begin
                    nv_erase = 1'b1;
                end
            end else if (is_ram) begin
                q_nxt.ack = 1'b1;
                q_nxt.ptr = BUS_ADDR;
                if (BUS_ADDR == `CDU_REG_UPDCTL) begin
                    q_nxt.rdata = {5'b0_0000, q_r.erase_en, 1'b0, q_r.transp};
                    if (BUS_WR) begin
                        q_nxt.transp = BUS_WDATA[`CDU_UPD_TRANSP];
                        q_nxt.erase_en = BUS_WDATA[`CDU_UPD_ERASE];
                        xfer_all = BUS_WDATA[`CDU_UPD_COMMIT];
                    end
                end else if (BUS_ADDR == `CDU_REG_UDL) begin
                    if (BUS_WR && BUS_WDATA[`CDU_UDL_REQ]) begin
                        q_nxt.st = CDU_LOAD_A;
                        q_nxt.idx = '0;
                        q_nxt.boot = 1'b0;
                    end
                end else if (BUS_ADDR < 16'(`CDU_CFG_BYTES)) begin
                    q_nxt.rdata = lat_a[BUS_ADDR[7:0]];
                    wr_a = BUS_WR;
                    wr_b = BUS_WR && q_r.transp;
                end
            end else if (is_nv) begin
                q_nxt.ptr = BUS_ADDR;
                q_nxt.ack = 1'b1;
                if (in_seq_nv && !SEQ_HALTED) begin
                    q_nxt.ack = 1'b0;
                end else if (fr_busy && (in_cfg_nv || in_user_nv)) begin
                    q_nxt.rdata = 8'h00;
                end else begin
                    q_nxt.rdata = nv[nv_idx];
                    nv_wr = BUS_WR && nv[nv_idx] == `CDU_BLANK;
                end
            end
        end
        // a latch write landing on a reload step is dropped: the reload byte wins
        if (ld_a && BUS_REQ && BUS_WR && wr_a) begin
            wr_a = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            q_r <= '{st: CDU_WAIT_UV, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // memories carry no reset: latches are refilled by the download, the store is nonvolatile
    always_ff @(posedge CLK_SYS) begin
        if (ld_a) begin
            lat_a[q_r.idx[7:0]] <= nv[q_r.idx];
        end
        if (wr_a) begin
            lat_a[wr_idx] <= wr_data;
        end
        for (int i = 0; i < `CDU_CFG_BYTES; i++) begin
            if (xfer_all) begin
                lat_b[i] <= lat_a[i];
            end
        end
        if (wr_b) begin
            lat_b[wr_idx] <= wr_data;
        end
        if (nv_wr) begin
            nv[nv_idx] <= wr_data;
        end
        if (nv_erase) begin
            for (int j = 0; j < `CDU_PAGE_BYTES; j++) begin
                nv[{erase_page, 5'(j)}] <= `CDU_BLANK;
            end
        end
    end

    assign BUS_DONE = q_r.done;
    assign BUS_ACK = q_r.ack;
    assign BUS_RDATA = q_r.rdata;
    assign CFG_Q = q_r.cfg_q;
    assign CFG_READY = q_r.ready;
    assign SEQ_WORD = q_r.seq_word;
    assign SEQ_VALID = q_r.seq_valid;

    sequence s_load_end;
        q_r.st == CDU_LOAD_A && q_r.idx == 10'(`CDU_CFG_BYTES - 1);
    endsequence
    sequence s_xfer;
        q_r.st == CDU_XFER;
    endsequence

    property p_uv_gate;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        q_r.st == CDU_WAIT_UV && !q_r.uv_ok |=> q_r.st == CDU_WAIT_UV;
    endproperty
    a_uv_gate: assert property (p_uv_gate) else $error("download began below lockout");

    property p_load_then_xfer;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        s_load_end |=> s_xfer ##1 q_r.ready;
    endproperty
    a_load_then_xfer: assert property (p_load_then_xfer) else $error("transfer missed after fill");

    property p_seq_delay;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        s_xfer ##0 q_r.boot |=> q_r.st == CDU_SEQ_WAIT [*8];
    endproperty
    a_seq_delay: assert property (p_seq_delay) else $error("state load too early");

    property p_nack_early;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        BUS_REQ && !q_r.ready |=> BUS_DONE && !BUS_ACK;
    endproperty
    a_nack_early: assert property (p_nack_early) else $error("access acked before download");

    property p_transp;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        wr_a |-> wr_b == q_r.transp;
    endproperty
    a_transp: assert property (p_transp) else $error("second stage write wrong for mode");

    property p_commit_zero;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        BUS_DONE |-> !(q_r.rdata[`CDU_UPD_COMMIT]) || $past(BUS_ADDR) != `CDU_REG_UPDCTL;
    endproperty
    a_commit_zero: assert property (p_commit_zero) else $error("commit bit read back set");

    property p_seq_nack;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        BUS_REQ && !BUS_ERASE && q_r.ready && q_r.st == CDU_RUN && in_seq_nv && !SEQ_HALTED
        |=> BUS_DONE && !BUS_ACK;
    endproperty
    a_seq_nack: assert property (p_seq_nack) else $error("state range access acked");

    property p_fr_block;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        BUS_REQ && fr_busy && (in_cfg_nv || in_user_nv) |-> !nv_wr;
    endproperty
    a_fr_block: assert property (p_fr_block) else $error("recorder range modified");

    property p_erase_gate;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        nv_erase |-> q_r.erase_en && BUS_ERASE;
    endproperty
    a_erase_gate: assert property (p_erase_gate) else $error("erase without enable");

    property p_blank_only;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        nv_wr |-> nv[nv_idx] == `CDU_BLANK && !wr_a && !wr_b;
    endproperty
    a_blank_only: assert property (p_blank_only) else $error("nonblank or latch write");

    property p_fetch_time;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        q_r.st == CDU_RUN && SEQ_NEXT && SEQ_NEXT_IDX != 6'h3F |=> q_r.st == CDU_SEQ_FETCH [*8];
    endproperty
    a_fetch_time: assert property (p_fetch_time) else $error("state fetch too short");
endmodule
`default_nettype wire

// ===== testbench/cdu_master.sv
// bus master model facing the configuration loader
`timescale 1ns/1ps
`default_nettype none
module cdu_master (
    // clock
    input wire logic clk_sys,
    // request side
    output logic bus_req,
    output logic bus_wr,
    output logic bus_erase,
    output logic [15:0] bus_addr,
    output logic [7:0] bus_wdata,
    // answer side
    input wire logic bus_done,
    input wire logic bus_ack,
    input wire logic [7:0] bus_rdata
);
    initial begin
        bus_req = 1'b0;
        bus_wr = 1'b0;
        bus_erase = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
    end

    // one byte access, the address always travels with the request; an erase acts on the stored pointer instead
    task automatic xfer(input logic wr, input logic er, input logic [15:0] a, input logic [7:0] d,
                        output logic ack, output logic [7:0] q, output logic seen);
        int n;
        @(negedge clk_sys);
        bus_req = 1'b1;
        bus_wr = wr;
        bus_erase = er;
        bus_addr = a;
        bus_wdata = d;
        @(negedge clk_sys);
        bus_req = 1'b0;
        // released address, data and write lines show the inverse so a stale value never passes for a live one
        bus_addr = ~a;
        bus_wdata = ~d;
        bus_wr = ~wr;
        bus_erase = 1'b0;
        seen = 1'b0;
        ack = 1'b0;
        q = 8'h00;
        for (n = 0; n < 4 && seen !== 1'b1; n++) begin
            if (bus_done === 1'b1) begin
                seen = 1'b1;
                ack = bus_ack;
                q = bus_rdata;
            end else begin
                @(negedge clk_sys);
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== testbench/config_download_and_update_test.sv
// self-checking bench of the configuration loader
`timescale 1ns/1ps
`default_nettype none
module config_download_and_update_test;
    import cdu_pkg::*;
    localparam int DLY = 20;
    localparam int FET = 10;
    logic CLK_SYS, RESET_N, LOCKOUT_CLEAR, BUS_REQ, BUS_WR, BUS_ERASE, BUS_DONE, BUS_ACK;
    logic CFG_READY, SEQ_HALTED, SEQ_NEXT, SEQ_VALID, FR_ENABLED, FR_TRIGGERS_ANY;
    logic [15:0] BUS_ADDR;
    logic [7:0] BUS_WDATA, BUS_RDATA, CFG_SEL, CFG_Q;
    logic [5:0] SEQ_NEXT_IDX;
    logic [63:0] SEQ_WORD;
    int err_count, compares;
    logic [31:0] rnd;
    logic [7:0] nvm [0:1023];
    logic ack, seen;
    logic [7:0] q;

    cdu_loader #(.SEQ_DELAY_CYC(DLY), .SEQ_FETCH_CYC(FET)) dut_u (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
        .LOCKOUT_CLEAR(LOCKOUT_CLEAR), .BUS_REQ(BUS_REQ), .BUS_WR(BUS_WR), .BUS_ERASE(BUS_ERASE),
        .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_DONE(BUS_DONE), .BUS_ACK(BUS_ACK),
        .BUS_RDATA(BUS_RDATA), .CFG_SEL(CFG_SEL), .CFG_Q(CFG_Q), .CFG_READY(CFG_READY),
        .SEQ_HALTED(SEQ_HALTED), .SEQ_NEXT(SEQ_NEXT), .SEQ_NEXT_IDX(SEQ_NEXT_IDX), .SEQ_WORD(SEQ_WORD),
        .SEQ_VALID(SEQ_VALID), .FR_ENABLED(FR_ENABLED), .FR_TRIGGERS_ANY(FR_TRIGGERS_ANY));
    cdu_master mst_u (.clk_sys(CLK_SYS), .bus_req(BUS_REQ), .bus_wr(BUS_WR), .bus_erase(BUS_ERASE),
        .bus_addr(BUS_ADDR), .bus_wdata(BUS_WDATA), .bus_done(BUS_DONE), .bus_ack(BUS_ACK),
        .bus_rdata(BUS_RDATA));

    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    function automatic logic [63:0] seword(input int s);
        logic [63:0] w;
        for (int k = 0; k < 8; k++) begin
            w[8*k +: 8] = nvm[512 + s * 8 + k];
        end
        return w;
    endfunction

    task automatic stop_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen_v, input logic [63:0] exp_v);
        compares++;
        if (seen_v !== exp_v) begin
            $display("[ERR] %0t seen %h expected %h", $time, seen_v, exp_v);
            err_count++;
        end
    endtask

    // a missing answer or a wait that ran out is counted and ends the run
    task automatic expire(input logic hit);
        if (hit !== 1'b1) begin
            err_count++;
            stop_test();
        end
    endtask

    task automatic acc(input logic wr, input logic er, input logic [15:0] a, input logic [7:0] d);
        mst_u.xfer(wr, er, a, d, ack, q, seen);
        expire(seen);
    endtask

    // one request pulse to the engine, then time for the fetch to finish
    task automatic seq_pulse(input int n);
        SEQ_NEXT_IDX = 6'(n);
        SEQ_NEXT = 1'b1;
        @(negedge CLK_SYS);
        SEQ_NEXT = 1'b0;
        repeat (FET + 2) @(negedge CLK_SYS);
    endtask

    task automatic cfg_rd(input int i);
        CFG_SEL = 8'(i);
        repeat (2) @(negedge CLK_SYS);
    endtask

    initial begin
        CLK_SYS = 1'b0;
        forever #20 CLK_SYS = ~CLK_SYS;
    end

    initial begin : main
        int i, k, idx;
        logic [7:0] v;
        rnd = 32'h4e7f;
        err_count = 0;
        compares = 0;
        RESET_N = 1'b0;
        LOCKOUT_CLEAR = 1'b0;
        CFG_SEL = 8'h00;
        SEQ_HALTED = 1'b0;
        SEQ_NEXT = 1'b0;
        SEQ_NEXT_IDX = 6'h00;
        FR_ENABLED = 1'b0;
        FR_TRIGGERS_ANY = 1'b0;
        // reserved pages stay blank, byte 5 left blank for the store write case
        for (i = 0; i < 1024; i++) begin
            nvm[i] = (i >= 160 && i < 256) ? 8'hFF : 8'(xs());
        end
        nvm[5] = 8'hFF;
        for (i = 0; i < 1024; i++) begin
            dut_u.nv[i] = nvm[i];
        end
        repeat (12) @(negedge CLK_SYS);
        RESET_N = 1'b1;
        acc(1'b0, 1'b0, 16'h0010, 8'h00);
        check(ack, 1'b0);
        repeat (200) @(negedge CLK_SYS);
        check(CFG_READY, 1'b0);
        LOCKOUT_CLEAR = 1'b1;
        for (i = 0; i < 400 && CFG_READY !== 1'b1; i++) begin
            @(negedge CLK_SYS);
        end
        check(CFG_READY, 1'b1);
        expire(CFG_READY);
        for (i = 0; i < 100 && SEQ_VALID !== 1'b1; i++) begin
            @(negedge CLK_SYS);
        end
        check(SEQ_VALID, 1'b1);
        expire(SEQ_VALID);
        check(i >= DLY && i <= DLY + FET + 4, 1'b1);
        check(SEQ_WORD, seword(0));
        for (k = 0; k < 6; k++) begin
            idx = xs() % 128;
            cfg_rd(idx);
            check(CFG_Q, nvm[idx]);
        end
        // staged write, then commit; byte 5 is kept for the store write case
        idx = 6 + xs() % 122;
        v = nvm[idx] ^ (8'(xs()) | 8'h01);
        acc(1'b1, 1'b0, 16'(idx), v);
        check(ack, 1'b1);
        acc(1'b0, 1'b0, 16'(idx), 8'h00);
        check(q, v);
        cfg_rd(idx);
        check(CFG_Q, nvm[idx]);
        acc(1'b1, 1'b0, 16'h0090, 8'h02);
        cfg_rd(idx);
        check(CFG_Q, v);
        acc(1'b0, 1'b0, 16'h0090, 8'h00);
        check(q, 8'h00);
        // transparent write lands at once; a commit given with it reads back zero
        acc(1'b1, 1'b0, 16'h0090, 8'h03);
        acc(1'b0, 1'b0, 16'h0090, 8'h00);
        check(q, 8'h01);
        v = ~v;
        acc(1'b1, 1'b0, 16'(idx), v);
        cfg_rd(idx);
        check(CFG_Q, v);
        acc(1'b1, 1'b0, 16'h0090, 8'h00);
        // store write leaves the latches until a reload is asked for
        acc(1'b1, 1'b0, 16'hF805, 8'h3C);
        check(ack, 1'b1);
        cfg_rd(5);
        check(CFG_Q, 8'hFF);
        acc(1'b1, 1'b0, 16'hF805, 8'hC3);
        acc(1'b0, 1'b0, 16'hF805, 8'h00);
        check(q, 8'h3C);
        nvm[5] = 8'h3C;
        acc(1'b1, 1'b0, 16'h00D8, 8'h01);
        ack = 1'b0;
        for (i = 0; i < 500 && ack !== 1'b1; i++) begin
            acc(1'b0, 1'b0, 16'h0000, 8'h00);
        end
        expire(ack);
        cfg_rd(5);
        check(CFG_Q, 8'h3C);
        cfg_rd(idx);
        check(CFG_Q, nvm[idx]);
        // page erase: acked but not carried out without enable, then only the pointer page
        acc(1'b0, 1'b0, 16'hF903, 8'h00);
        check(q, nvm[259]);
        acc(1'b1, 1'b1, 16'h0000, 8'hFE);
        acc(1'b0, 1'b0, 16'hF903, 8'h00);
        check(q, nvm[259]);
        acc(1'b1, 1'b0, 16'h0090, 8'h04);
        acc(1'b0, 1'b0, 16'hF900, 8'h00);
        acc(1'b1, 1'b1, 16'h0000, 8'hFE);
        acc(1'b0, 1'b0, 16'hF91F, 8'h00);
        check(q, 8'hFF);
        acc(1'b0, 1'b0, 16'hF920, 8'h00);
        check(q, nvm[288]);
        acc(1'b1, 1'b0, 16'h0090, 8'h00);
        // state range needs a halted engine
        acc(1'b0, 1'b0, 16'hFA00, 8'h00);
        check(ack, 1'b0);
        SEQ_HALTED = 1'b1;
        acc(1'b0, 1'b0, 16'hFA08, 8'h00);
        check(q, nvm[520]);
        SEQ_HALTED = 1'b0;
        // a hole between the register space and the store is refused
        acc(1'b0, 1'b0, 16'hF000, 8'h00);
        check(ack, 1'b0);
        // running recorder hides the configuration and user store, an idle one does not
        FR_ENABLED = 1'b1;
        FR_TRIGGERS_ANY = 1'b1;
        acc(1'b0, 1'b0, 16'hF910, 8'h00);
        check({ack, q}, {1'b1, 8'h00});
        acc(1'b1, 1'b0, 16'hF91F, 8'h5A);
        FR_TRIGGERS_ANY = 1'b0;
        acc(1'b0, 1'b0, 16'hF91F, 8'h00);
        check(q, 8'hFF);
        acc(1'b1, 1'b0, 16'hF91F, 8'h5A);
        acc(1'b0, 1'b0, 16'hF91F, 8'h00);
        check(q, 8'h5A);
        // state fetches on demand
        for (k = 0; k < 3; k++) begin
            idx = 1 + xs() % 62;
            seq_pulse(idx);
            check(SEQ_WORD, seword(idx));
        end
        // the reserved last state is never fetched, the word stays
        seq_pulse(63);
        check(SEQ_WORD, seword(idx));
        stop_test();
    end
endmodule
`default_nettype wire
